// ### dpw_wiper_i2c_slave.sv
// two-wire write slave steering a 256 tap wiper latch and its stored copy
//
// Contract
// [RULE_01] address top four bits are 0101
// [RULE_02] next two address bits are build parameter
// [RULE_03] address low bit follows select pin
// [RULE_04] eighth bit low writes, high is nop
// [RULE_05] ack low through ninth clock high
// [RULE_06] master supplies the ninth clock pulse
// [RULE_07] sda falling with scl high starts
// [RULE_08] sda rising with scl high stops
// [RULE_09] idle bus leaves both lines high
// [RULE_10] sda stable while scl high
// [RULE_11] start, address, command, data, stop
// [RULE_12] master starts transfers and clocks
// [RULE_13] scl is input only, no stretching
// [RULE_14] sda sampled, driven only as pull-down
// [RULE_15] respond only to own address
// [RULE_16] shift register decodes, steers data byte
// [RULE_17] eight bits pick wiper among 256 taps
// [RULE_18] latch write moves wiper at once
// [RULE_19] stored copy write only saves value
// [RULE_20] latch cleared at power-on reset
// [RULE_21] power-on copies stored value into latch
// [RULE_22] codes 11h latch, 21h stored copy
// [RULE_23] codes 61h recall, 51h save
// [RULE_24] power-up load done within ten us
// [RULE_25] nop or unknown code changes nothing
// [RULE_26] start or stop mid-byte abandons transfer
`include "dpw_cfg.svh"

module dpw_wiper_i2c_slave #(
  parameter logic [1:0] FACTORY_BITS = 2'h0,
  parameter int AXI_ADDR_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // two-wire link pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addressSelectPin,
  // wiper side
  output logic [7:0] wiperPos,
  output logic initDone,
  // axi4-lite write address
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [`DPW_INIT_CNT_W-1:0] INIT_LAST =
    `DPW_INIT_CNT_W'(`DPW_INIT_CYCLES - 1);

  dpw_pkg::dpw_state_s r;
  dpw_pkg::dpw_state_s n;

  logic sclS;
  logic sdaS;
  logic selS;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [6:0] ownAddr;
  logic respond;
  logic wrFire;
  logic arFire;
  logic arBad;
  logic [1:0] arIdx;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; idle lines read high

  dpw_sync #(
    .WIDTH(3),
    .RST_VAL(3'h7)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({scl, sdaIn, addressSelectPin}),
    .q({sclS, sdaS, selS})
  );

  ////////////////////////////////////////////////////////////////////////
  // link events from the synchronised levels

  // scl is only sampled, never driven [RULE_13]
  assign sclRise = sclS & ~r.sclPrev;
  assign sclFall = ~sclS & r.sclPrev;
  // sda edges while scl stays high [RULE_07] [RULE_08]
  assign startCond = sclS & r.sclPrev & r.sdaPrev & ~sdaS;
  assign stopCond = sclS & r.sclPrev & ~r.sdaPrev & sdaS;

  // fixed prefix, factory pair, strap bit [RULE_01] [RULE_02] [RULE_03]
  assign ownAddr = {`DPW_ADDR_PREFIX, FACTORY_BITS, selS};

  // no answers until the power-up load is finished
  assign respond = r.slaveEn & r.initDone;

  ////////////////////////////////////////////////////////////////////////
  // register bus decode helpers

  assign wrFire = r.awHeld & r.wHeld & ~r.bvalid;
  assign arFire = r.arready & s_axi_arvalid;
  assign arIdx = s_axi_araddr[3:2];
  assign arBad = (s_axi_araddr[AXI_ADDR_W-1:4] != '0) |
    (s_axi_araddr[1:0] != 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = r;
    n.sclPrev = sclS;
    n.sdaPrev = sdaS;
    n.sdaOut = 1'b0;

    // power-up: latch starts cleared, then takes the stored copy
    if (!r.initDone) begin
      if (r.initCnt == INIT_LAST) begin
        n.initDone = 1'b1;
        n.latch = r.stored; // [RULE_21] [RULE_24]
      end else begin
        n.initCnt = r.initCnt + 1'b1;
      end
    end

    // ---------------- axi4-lite write path ----------------
    if (r.awready && s_axi_awvalid) begin
      n.awHeld = 1'b1;
      n.awIdx = s_axi_awaddr[3:2];
      n.awBad = (s_axi_awaddr[AXI_ADDR_W-1:4] != '0) |
        (s_axi_awaddr[1:0] != 2'h0);
    end
    if (r.wready && s_axi_wvalid) begin
      n.wHeld = 1'b1;
      n.wByte = s_axi_wdata[7:0];
      n.wLane0 = s_axi_wstrb[0];
    end
    if (wrFire) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = r.awBad ? `DPW_RESP_SLVERR : `DPW_RESP_OKAY;
      if (!r.awBad && r.wLane0) begin
        unique case (r.awIdx)
          `DPW_IDX_WIPER: n.latch = r.wByte;
          `DPW_IDX_STORED: n.stored = r.wByte;
          `DPW_IDX_CTRL: n.slaveEn = r.wByte[`DPW_CTRL_SLAVE_EN];
          `DPW_IDX_STATUS: n.slaveEn = r.slaveEn;
        endcase
      end
    end else if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // one write outstanding; ready drops while held or answering
    n.awready = ~n.awHeld & ~n.bvalid;
    n.wready = ~n.wHeld & ~n.bvalid;

    // ---------------- axi4-lite read path ----------------
    if (arFire) begin
      n.rvalid = 1'b1;
      n.rdata = 32'h0;
      n.rresp = arBad ? `DPW_RESP_SLVERR : `DPW_RESP_OKAY;
      if (!arBad) begin
        unique case (arIdx)
          `DPW_IDX_WIPER: n.rdata[7:0] = r.latch;
          `DPW_IDX_STORED: n.rdata[7:0] = r.stored;
          `DPW_IDX_STATUS: begin
            n.rdata[`DPW_ST_INIT_DONE] = r.initDone;
            n.rdata[`DPW_ST_BUS_BUSY] = (r.st != dpw_pkg::DPW_IDLE);
            n.rdata[`DPW_ST_LAST_NOP] = r.lastNop;
            n.rdata[`DPW_ST_LAST_CMD_LSB +: 8] = r.lastCmd;
          end
          `DPW_IDX_CTRL: n.rdata[`DPW_CTRL_SLAVE_EN] = r.slaveEn;
        endcase
      end
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = ~n.rvalid;

    // ---------------- two-wire serial path ----------------
    // link updates follow the bus path so they win a same-cycle clash
    if (startCond) begin
      // a repeated start also lands here, dropping any partial byte
      n.st = dpw_pkg::DPW_ADDR; // [RULE_07] [RULE_26]
      n.bitCnt = 4'h0;
      n.sdaOe = 1'b0;
    end else if (stopCond) begin
      n.st = dpw_pkg::DPW_IDLE; // [RULE_08] [RULE_26]
      n.bitCnt = 4'h0;
      n.sdaOe = 1'b0; // [RULE_09]
    end else begin
      unique case (r.st)
        dpw_pkg::DPW_IDLE: begin
          n.sdaOe = 1'b0; // [RULE_09]
        end

        dpw_pkg::DPW_ADDR, dpw_pkg::DPW_CMD, dpw_pkg::DPW_DATA: begin
          // shift one bit per scl high, msb first [RULE_16]
          if (sclRise && r.bitCnt != 4'h8) begin
            n.shift = {r.shift[6:0], sdaS};
            n.bitCnt = r.bitCnt + 4'h1;
          end
          // the falling edge after bit eight opens the ack slot
          if (sclFall && r.bitCnt == 4'h8) begin
            n.bitCnt = 4'h0;
            unique case (r.st)
              dpw_pkg::DPW_ADDR: begin
                if (respond && r.shift[7:1] == ownAddr) begin // [RULE_15]
                  n.nop = r.shift[0]; // [RULE_04]
                  n.sdaOe = 1'b1; // [RULE_05] [RULE_14]
                  n.st = dpw_pkg::DPW_ADDR_ACK;
                end else begin
                  // other slaves' traffic, or any while disabled or loading: stay off the line till start or stop
                  n.st = dpw_pkg::DPW_SKIP;
                end
              end
              dpw_pkg::DPW_CMD: begin
                n.cmd = r.shift;
                n.sdaOe = 1'b1; // [RULE_05]
                n.st = dpw_pkg::DPW_CMD_ACK;
              end
              default: begin
                // data byte: act on the decoded command [RULE_16]
                n.sdaOe = 1'b1; // [RULE_05]
                n.st = dpw_pkg::DPW_DATA_ACK;
                n.lastCmd = r.cmd;
                n.lastNop = r.nop;
                if (!r.nop) begin // [RULE_25]
                  unique case (r.cmd)
                    `DPW_CMD_WIPER_LATCH_WRITE: begin
                      // wiper follows latch directly [RULE_17] [RULE_18]
                      n.latch = r.shift; // [RULE_22]
                    end
                    `DPW_CMD_STORED_COPY_WRITE: begin
                      n.stored = r.shift; // [RULE_19] [RULE_22]
                    end
                    `DPW_CMD_RECALL_STORED_TO_LATCH: begin
                      n.latch = r.stored; // [RULE_23]
                    end
                    `DPW_CMD_SAVE_LATCH_TO_STORED: begin
                      n.stored = r.latch; // [RULE_23]
                    end
                    default: begin
                      n.latch = n.latch; // [RULE_25]
                    end
                  endcase
                end
              end
            endcase
          end
        end

        dpw_pkg::DPW_ADDR_ACK, dpw_pkg::DPW_CMD_ACK: begin
          // pull-down held across the ninth high phase [RULE_05]
          if (sclFall) begin
            n.sdaOe = 1'b0; // [RULE_14]
            n.bitCnt = 4'h0;
            n.st = (r.st == dpw_pkg::DPW_ADDR_ACK) ?
              dpw_pkg::DPW_CMD : dpw_pkg::DPW_DATA;
          end
        end

        dpw_pkg::DPW_DATA_ACK: begin
          // only one data byte counts; later bytes go unanswered
          if (sclFall) begin
            n.sdaOe = 1'b0; // [RULE_14]
            n.st = dpw_pkg::DPW_SKIP;
          end
        end

        dpw_pkg::DPW_SKIP: begin
          n.sdaOe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= dpw_pkg::DPW_IDLE;
      r.latch <= `DPW_LATCH_RST; // [RULE_20]
      r.stored <= `DPW_STORED_RST;
      r.slaveEn <= `DPW_SLAVE_EN_RST;
      r.sclPrev <= 1'b1;
      r.sdaPrev <= 1'b1;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register

  assign sdaOut = r.sdaOut;
  assign sdaOe = r.sdaOe;
  assign wiperPos = r.latch; // [RULE_17]
  assign initDone = r.initDone;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

endmodule

// ### dpw_cfg.svh
// offsets, field positions, reset values and timing counts of the wiper slave
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// register word offsets (byte addresses)
`define DPW_OFF_WIPER 8'h00
`define DPW_OFF_STORED 8'h04
`define DPW_OFF_STATUS 8'h08
`define DPW_OFF_CTRL 8'h0c

// register word indices, byte address bits [3:2]
`define DPW_IDX_WIPER 2'h0
`define DPW_IDX_STORED 2'h1
`define DPW_IDX_STATUS 2'h2
`define DPW_IDX_CTRL 2'h3

// status field positions
`define DPW_ST_INIT_DONE 0
`define DPW_ST_BUS_BUSY 1
`define DPW_ST_LAST_NOP 2
`define DPW_ST_LAST_CMD_LSB 8

// control field positions
`define DPW_CTRL_SLAVE_EN 0

// reset values
`define DPW_LATCH_RST 8'h00
`define DPW_STORED_RST 8'h80
`define DPW_SLAVE_EN_RST 1'b1

// slave address and command codes
`define DPW_ADDR_PREFIX 4'h5
`define DPW_CMD_WIPER_LATCH_WRITE 8'h11
`define DPW_CMD_STORED_COPY_WRITE 8'h21
`define DPW_CMD_RECALL_STORED_TO_LATCH 8'h61
`define DPW_CMD_SAVE_LATCH_TO_STORED 8'h51

// bus answers
`define DPW_RESP_OKAY 2'h0
`define DPW_RESP_SLVERR 2'h2

// timing: init time in ns, clock period in ns, derived cycle count
`define DPW_INIT_TIME_NS 10000
`define DPW_CLK_PERIOD_NS 4
`define DPW_INIT_CYCLES (`DPW_INIT_TIME_NS / `DPW_CLK_PERIOD_NS)
`define DPW_INIT_CNT_W 12

`endif

// ### dpw_pkg.sv
// types of the wiper slave: serial states and the registered state record
package dpw_pkg;

  // gray coded along start, address, command, data
  typedef enum logic [2:0] {
    DPW_IDLE = 3'h0,
    DPW_ADDR = 3'h1,
    DPW_ADDR_ACK = 3'h3,
    DPW_CMD = 3'h2,
    DPW_CMD_ACK = 3'h6,
    DPW_DATA = 3'h7,
    DPW_DATA_ACK = 3'h5,
    DPW_SKIP = 3'h4
  } dpw_state_e;

  typedef struct packed {
    // serial side
    dpw_state_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic nop;
    logic sdaOe;
    logic sdaOut;
    logic sclPrev;
    logic sdaPrev;
    // wiper storage
    logic [7:0] latch;
    logic [7:0] stored;
    logic [11:0] initCnt;
    logic initDone;
    logic slaveEn;
    logic [7:0] lastCmd;
    logic lastNop;
    // register bus
    logic awready;
    logic wready;
    logic awHeld;
    logic wHeld;
    logic [1:0] awIdx;
    logic awBad;
    logic [7:0] wByte;
    logic wLane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dpw_state_s;

endpackage

// ### dpw_sync.sv
// two flip-flop synchroniser, one stage pair per bit
module dpw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          meta <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

// ### dpw_i2c_master_model.sv
// two-wire bus master model: drives scl, pulls sda low
module dpw_i2c_master_model (
  // link pins
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter of the 125 ns link clock
  localparam realtime Q = 31.25;
  // idle: both lines released, scl stands still
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // also a repeated start from mid-byte
  task automatic start();
    sdaLow = 1'b0;
    #(Q);
    scl = 1'b1;
    #(Q);
    sdaLow = 1'b1;
    #(Q);
    scl = 1'b0;
    #(Q);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #(Q);
    scl = 1'b1;
    #(Q);
    sdaLow = 1'b0;
    #(4 * Q);
  endtask
  // sda moves only while scl is low
  task automatic bitOut(input logic b, output logic seen);
    sdaLow = !b;
    #(Q);
    scl = 1'b1;
    #(Q);
    seen = sda;
    #(Q);
    scl = 1'b0;
    #(Q);
  endtask
  // msb first; a short count leaves the byte cut off
  task automatic sendByte(input logic [7:0] b, input int n,
                          output logic ack);
    logic seen;
    seen = 1'b1;
    for (int i = 7; i > 7 - n; i--)
      bitOut(b[i], seen);
    if (n == 8)
      bitOut(1'b1, seen);
    ack = !seen;
  endtask
endmodule

// ### dpw_wiper_i2c_slave_props.sv
// assertions on the pins of the wiper slave
module dpw_wiper_i2c_slave_props (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link and wiper
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [7:0] wiperPos,
  input wire logic initDone,
  // write answer
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // edges since release, saturating
  logic [11:0] upCnt;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      upCnt <= 12'h000;
    else if (upCnt != 12'hfff)
      upCnt <= upCnt + 12'h001;
  //////////////////////////////////////////////////////////////////////////////
  pull_down_only_a: assert property (sdaOe |-> !sdaOut)
    else $error("sda driven high");
  ack_scl_low_a: assert property ($changed(sdaOe) |-> !scl)
    else $error("ack moved in scl high");
  ack_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("ack too short");
  init_bound_a: assert property (upCnt >= 12'h9c4 |-> initDone)
    else $error("load late");
  latch_clear_a: assert property (!initDone |-> wiperPos == 8'h00)
    else $error("wiper not clear");
  early_ack_a: assert property (!initDone |-> !sdaOe)
    else $error("ack before load");
  stop_free_a: assert property (scl && $rose(sdaIn) |-> !sdaOe [*8])
    else $error("ack after stop");
  start_addr_a: assert property (scl && $fell(sdaIn) |-> !sdaOe [*8])
    else $error("ack after start");
  cover property ($rose(sdaOe));
  cover property ($rose(initDone));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// ### dpw_wiper_i2c_slave_test.sv
// self-checking bench of the wiper slave
`include "dpw_cfg.svh"
module dpw_wiper_i2c_slave_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [6:0] ad;
    logic nop;
    logic [7:0] c;
    logic ak;
  } dpw_frame_s;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic scl, sdaLow, sdaIn, sdaOut, sdaOe, initDone;
  logic addressSelectPin = 1'b0;
  logic [7:0] wiperPos;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int nFail = 0, checkCount = 0, cycles = 0, t0 = 0;
  // open drain with pull-up
  assign sdaIn = !(sdaOe || sdaLow);
  dpw_i2c_master_model u_master (.scl, .sdaLow, .sda(sdaIn));
  dpw_wiper_i2c_slave #(.FACTORY_BITS(2'h2), .AXI_ADDR_W(8)) u_dut (
    .clock, .nrst, .scl, .sdaIn, .sdaOut, .sdaOe, .addressSelectPin,
    .wiperPos, .initDone, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    forever #2 clock = ~clock;
  end
  // some fourteen frames of ~900 cycles plus the load
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nFail++;
      tallyAndFinish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic axiWr(logic [7:0] a, logic [7:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRd(logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // {latch, stored} after one accepted command
  function automatic logic [15:0] applyCmd(logic [15:0] ls, logic [7:0] c,
                                           logic [7:0] d);
    case (c)
      8'h11: return {d, ls[7:0]};
      8'h21: return {ls[15:8], d};
      8'h61: return {ls[7:0], ls[7:0]};
      8'h51: return {ls[15:8], ls[15:8]};
      default: return ls;
    endcase
  endfunction
  task automatic cmpRegs(logic [15:0] ls);
    logic [31:0] rd;
    logic [1:0] rr;
    check("wiper", 32'(wiperPos), 32'(ls[15:8]));
    axiRd(`DPW_OFF_STORED, rd, rr);
    check("stored", rd, 32'(ls[7:0]));
  endtask
  task automatic linkWr(logic [6:0] ad, logic nop, logic [7:0] c,
                        logic [7:0] d, logic ak);
    logic ack;
    u_master.start();
    u_master.sendByte({ad, nop}, 8, ack);
    check("addr ack", 32'(ack), 32'(ak));
    u_master.sendByte(c, 8, ack);
    check("cmd ack", 32'(ack), 32'(ak));
    u_master.sendByte(d, 8, ack);
    check("data ack", 32'(ack), 32'(ak));
    u_master.stop();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    dpw_frame_s fr [10];
    logic [6:0] oa;
    logic [15:0] ls;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] d;
    logic ack;
    void'($urandom(32'hb595));
    oa = {`DPW_ADDR_PREFIX, 2'h2, 1'($urandom)};
    addressSelectPin <= oa[0];
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t0 = cycles;
    // ignored until the power-up load is done
    linkWr(oa, 1'b0, 8'h11, 8'h3c, 1'b0);
    check("wiper before load", 32'(wiperPos), 32'h0);
    while (initDone !== 1'b1)
      @(posedge clock);
    check("load time", 32'(cycles - t0 <= 2502), 32'h1);
    ls = {`DPW_STORED_RST, `DPW_STORED_RST};
    cmpRegs(ls);
    fr = '{'{oa, 1'b0, 8'h11, 1'b1}, '{oa, 1'b0, 8'h21, 1'b1},
      '{oa, 1'b0, 8'h61, 1'b1}, '{oa, 1'b0, 8'h11, 1'b1},
      '{oa, 1'b0, 8'h51, 1'b1}, '{oa, 1'b0, 8'h33, 1'b1},
      '{oa, 1'b1, 8'h11, 1'b1}, '{oa ^ 7'h01, 1'b0, 8'h11, 1'b0},
      '{oa ^ 7'h04, 1'b0, 8'h11, 1'b0}, '{oa ^ 7'h40, 1'b0, 8'h21, 1'b0}};
    foreach (fr[i]) begin
      d = 8'($urandom);
      linkWr(fr[i].ad, fr[i].nop, fr[i].c, d, fr[i].ak);
      if (fr[i].ak && !fr[i].nop)
        ls = applyCmd(ls, fr[i].c, d);
      cmpRegs(ls);
    end
    // cut-off bytes leave nothing behind
    d = 8'($urandom);
    u_master.start();
    u_master.sendByte({oa, 1'b0}, 8, ack);
    u_master.sendByte(8'h21, 4, ack);
    linkWr(oa, 1'b0, 8'h11, d, 1'b1);
    u_master.start();
    u_master.sendByte({oa, 1'b0}, 8, ack);
    u_master.sendByte(8'h21, 8, ack);
    u_master.sendByte(~d, 5, ack);
    u_master.stop();
    ls[15:8] = d;
    cmpRegs(ls);
    d = 8'($urandom);
    axiWr(`DPW_OFF_WIPER, d, rr);
    check("wiper write resp", 32'(rr), 32'(`DPW_RESP_OKAY));
    check("wiper by bus", 32'(wiperPos), 32'(d));
    ls[15:8] = d;
    axiWr(8'h10, d, rr);
    check("unmapped write", 32'(rr), 32'(`DPW_RESP_SLVERR));
    axiRd(8'h01, rd, rr);
    check("unmapped read", {rd[29:0], rr}, 32'(`DPW_RESP_SLVERR));
    // strap flip moves the address; a disabled slave stays silent
    addressSelectPin <= ~oa[0];
    d = 8'($urandom);
    linkWr(oa ^ 7'h01, 1'b0, 8'h21, d, 1'b1);
    ls[7:0] = d;
    axiWr(`DPW_OFF_CTRL, 8'h00, rr);
    linkWr(oa ^ 7'h01, 1'b0, 8'h11, ~d, 1'b0);
    axiRd(`DPW_OFF_STATUS, rd, rr);
    check("status", rd, {16'h0, 8'h21, 8'h01});
    cmpRegs(ls);
    tallyAndFinish();
  end
endmodule
bind dpw_wiper_i2c_slave dpw_wiper_i2c_slave_props u_props (
  .clock, .nrst, .scl, .sdaIn, .sdaOut, .sdaOe, .wiperPos, .initDone,
  .s_axi_bvalid, .s_axi_bresp);
